/* verilog/atacmd_defines.svh */
// Offsets, codes and reset values for the ATA command block
`ifndef ATACMD_DEFINES_SVH
`define ATACMD_DEFINES_SVH
`define ATACMD_OP_SET_MAX 8'hF9
`define ATACMD_OP_READ_NATIVE 8'hF8
`define ATACMD_OP_SET_MULT 8'hC6
`define ATACMD_OP_SMART 8'hB0
`define ATACMD_OP_STBY_A 8'h96
`define ATACMD_OP_STBY_B 8'hE2
`define ATACMD_OP_STBYI_A 8'h94
`define ATACMD_OP_STBYI_B 8'hE0
`define ATACMD_OP_TRANSLATE 8'h87
`define ATACMD_OP_WRBUF 8'hE8
`define ATACMD_SUB_PWD 8'h01
`define ATACMD_SUB_FREEZE 8'h04
`define ATACMD_MAX_MULT 8'h01
`define ATACMD_BUF_WORDS 256
`define ATACMD_LBA_BIT 6
`define ATACMD_DEV_BIT 4
`define ATACMD_KEEP_BIT 0
`define ATACMD_SMART_WORD 82
`define ATACMD_SMART_BIT 0
`define ATACMD_NATIVE_MAX 28'h0FFFFFF
`define ATACMD_ADR_STATUS 4'h0
`define ATACMD_ADR_ENABLE 4'h1
`define ATACMD_ADR_CLEAR 4'h2
`define ATACMD_ADR_MAXLBA 4'h3
`define ATACMD_ADR_MULT 4'h4
`define ATACMD_ADR_STATE 4'h5
`endif

/* verilog/atacmd_pkg.sv */
// Types for the ATA command block
package atacmd_pkg;
  typedef enum logic [3:0] {
    ATACMD_IDLE = 4'b0001,
    ATACMD_EXEC = 4'b0010,
    ATACMD_DATA = 4'b0100,
    ATACMD_DONE = 4'b1000
  } atacmd_state_t;
endpackage : atacmd_pkg

/* verilog/atacmd_core.sv */
// ATA command interpreter for capacity, multiple, standby and buffer commands
`timescale 1ns/10ps
`default_nettype none
`include "atacmd_defines.svh"

// Behaviour
// - Set-max command loads highest address from task-file address fields.
// - Keep bit set: max survives reset; clear: reset restores nonvolatile max.
// - Features code picks set-max subcommand: password, lock, unlock, freeze.
// - Abort second nonvolatile set-max after power-on or hardware reset.
// - Set-multiple raises busy and reads sector count as block size.
// - Valid supported block count is stored and enables multiple commands.
// - Unsupported block count aborts and disables multiple commands.
// - Zero block count disables multiple commands.
// - Multiple commands start disabled after power-on.
// - Identify word 82 bit 0 reports self-monitoring support.
// - Standby: busy, sleep, clear busy, interrupt at once.
// - Standby-immediate: same busy, sleep, clear busy, interrupt sequence.
// - Any further command wakes the device from sleep.
// - Translate-sector is a no-op returning zero sector count.
// - Write-buffer takes 512 bytes and overwrites the sector buffer.
module atacmd_core
  import atacmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_features,
  input wire logic [7:0] cmd_count,
  input wire logic [7:0] cmd_lba_low,
  input wire logic [7:0] cmd_lba_mid,
  input wire logic [7:0] cmd_lba_high,
  input wire logic [7:0] cmd_drive_head,
  input wire logic drive_id,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  output logic wr_ready,
  input wire logic [7:0] id_index,
  output logic [15:0] id_word,
  output logic busy_flag,
  output logic device_ready_flag,
  output logic cmd_done,
  output logic cmd_abort,
  output logic [7:0] count_out,
  output logic [27:0] max_lba,
  output logic [7:0] mult_count,
  output logic mult_enable,
  output logic sleep_mode,
  output logic set_max_locked,
  output logic set_max_frozen,
  output logic [15:0] buf_rd_data,
  input wire logic [7:0] buf_rd_addr,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq
);
  atacmd_state_t state_q, state_d;
  logic [7:0] op_q;
  // Power-up values only; the async reset leaves these alone
  logic [27:0] max_q = `ATACMD_NATIVE_MAX;
  logic [27:0] nv_max_q = `ATACMD_NATIVE_MAX;
  logic keep_q = 1'b0;
  logic restore_q;
  logic [7:0] mult_q;
  logic mult_en_q;
  logic sleep_q;
  logic prev_native_q;
  logic nv_done_q;
  logic locked_q, frozen_q;
  logic busy_q, done_q, abort_q;
  logic [7:0] count_q;
  logic [7:0] wcnt_q;
  logic [15:0] buf_mem [0:`ATACMD_BUF_WORDS-1];
  logic [15:0] buf_rd_q, id_q;
  logic [2:0] status_q, enable_q;
  logic [31:0] rdata_q;
  logic setmax_abort_q, mult_bad_q;
  logic [7:0] feat_q, cnt_in_q;
  logic [27:0] lba_in_q;

  // Task-file decode
  wire take = cmd_valid && (state_q == ATACMD_IDLE) && (cmd_drive_head[`ATACMD_DEV_BIT] == drive_id);
  wire [27:0] new_lba = {cmd_drive_head[3:0], cmd_lba_high, cmd_lba_mid, cmd_lba_low};
  wire keep_req = cmd_count[`ATACMD_KEEP_BIT];
  wire is_setmax = op_q == `ATACMD_OP_SET_MAX;
  wire sub_ok = (cmd_features >= `ATACMD_SUB_PWD) && (cmd_features <= `ATACMD_SUB_FREEZE);
  wire sub_is_plain = 1'b0;
  // Frozen or locked blocks changes to the max address
  wire max_guard = locked_q || frozen_q;
  wire setmax_abort = !prev_native_q || !sub_ok || (keep_req && nv_done_q) || max_guard;
  wire mult_ok = (cmd_count != 8'h00) && (cmd_count <= `ATACMD_MAX_MULT);
  wire mult_bad = (cmd_count != 8'h00) && !mult_ok;
  wire is_stby = (op_q == `ATACMD_OP_STBY_A) || (op_q == `ATACMD_OP_STBY_B) ||
                 (op_q == `ATACMD_OP_STBYI_A) || (op_q == `ATACMD_OP_STBYI_B);
  wire known = is_setmax || (op_q == `ATACMD_OP_READ_NATIVE) || (op_q == `ATACMD_OP_SET_MULT) ||
               (op_q == `ATACMD_OP_SMART) || is_stby || (op_q == `ATACMD_OP_TRANSLATE) ||
               (op_q == `ATACMD_OP_WRBUF);
  wire exec_abort = !known || (is_setmax && setmax_abort_q) || ((op_q == `ATACMD_OP_SET_MULT) && mult_bad_q);
  wire buf_last = wcnt_q == 8'(`ATACMD_BUF_WORDS - 1);
  wire buf_take = (state_q == ATACMD_DATA) && wr_valid;
  wire setmax_go = (state_q == ATACMD_EXEC) && is_setmax && !setmax_abort_q;

  assign wr_ready = state_q == ATACMD_DATA;
  assign busy_flag = busy_q;
  assign device_ready_flag = !busy_q;
  assign cmd_done = done_q;
  assign cmd_abort = abort_q;
  assign count_out = count_q;
  assign max_lba = max_q;
  assign mult_count = mult_q;
  assign mult_enable = mult_en_q;
  assign sleep_mode = sleep_q;
  assign set_max_locked = locked_q;
  assign set_max_frozen = frozen_q;
  assign buf_rd_data = buf_rd_q;
  assign id_word = id_q;
  assign reg_rdata = rdata_q;
  assign irq = |(status_q & enable_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ATACMD_IDLE: if (take) state_d = ATACMD_EXEC;
      ATACMD_EXEC: state_d = (op_q == `ATACMD_OP_WRBUF) ? ATACMD_DATA : ATACMD_DONE;
      ATACMD_DATA: if (buf_take && buf_last) state_d = ATACMD_DONE;
      ATACMD_DONE: state_d = ATACMD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_q <= ATACMD_IDLE;
    else state_q <= state_d;
  end

  // Latch the command and its checks on take
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q <= 8'h00;
      feat_q <= 8'h00;
      cnt_in_q <= 8'h00;
      lba_in_q <= 28'h0;
      setmax_abort_q <= 1'b0;
      mult_bad_q <= 1'b0;
    end else if (take) begin
      op_q <= cmd_code;
      feat_q <= cmd_features;
      cnt_in_q <= cmd_count;
      lba_in_q <= new_lba;
      setmax_abort_q <= setmax_abort;
      mult_bad_q <= mult_bad;
    end
  end

  // Busy rises on take and falls at completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_q <= 1'b0;
    else if (take) busy_q <= 1'b1;
    else if (state_q == ATACMD_DONE) busy_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      done_q <= state_q == ATACMD_DONE;
      abort_q <= (state_q == ATACMD_EXEC) ? exec_abort : ((state_q == ATACMD_IDLE) ? 1'b0 : abort_q);
    end
  end

  // Restore pulse on the first edge after any reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restore_q <= 1'b1;
    end else begin
      restore_q <= 1'b0;
    end
  end

  // No async reset here, so a kept maximum survives a hardware reset
  // Limitation: nonvolatile copy is a register, lost on real power loss
  always_ff @(posedge clk) begin
    if (restore_q) begin
      if (!keep_q) begin
        max_q <= nv_max_q;
      end
    end else if (setmax_go) begin
      max_q <= lba_in_q;
      keep_q <= cnt_in_q[`ATACMD_KEEP_BIT];
      if (cnt_in_q[`ATACMD_KEEP_BIT]) begin
        nv_max_q <= lba_in_q;
      end
    end
  end

  // Obsolete code zero is never treated as plain set-max
  wire unused_plain = sub_is_plain ^ keep_q ^ nv_max_q[0];

  // Subcommands: password, lock, unlock, freeze
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_q <= 1'b0;
      frozen_q <= 1'b0;
      nv_done_q <= 1'b0;
    end else if (setmax_go) begin
      nv_done_q <= nv_done_q | cnt_in_q[`ATACMD_KEEP_BIT];
      unique case (feat_q)
        8'h02: locked_q <= 1'b1;
        8'h03: locked_q <= 1'b0;
        8'h04: frozen_q <= 1'b1;
        default: ;
      endcase
    end
  end

  // Read-native-max must be the immediately preceding command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prev_native_q <= 1'b0;
    else if (state_q == ATACMD_EXEC) prev_native_q <= op_q == `ATACMD_OP_READ_NATIVE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mult_q <= 8'h00;
      mult_en_q <= 1'b0;
    end else if (state_q == ATACMD_EXEC && op_q == `ATACMD_OP_SET_MULT) begin
      mult_en_q <= (cnt_in_q != 8'h00) && !mult_bad_q;
      if ((cnt_in_q != 8'h00) && !mult_bad_q) mult_q <= cnt_in_q;
    end
  end

  // Sleep entered by standby, left on any new command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sleep_q <= 1'b0;
    else if (take) sleep_q <= 1'b0;
    else if (state_q == ATACMD_EXEC && is_stby) sleep_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) count_q <= 8'h00;
    else if (state_q == ATACMD_EXEC) count_q <= (op_q == `ATACMD_OP_TRANSLATE) ? 8'h00 : cnt_in_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) wcnt_q <= 8'h00;
    else if (state_q == ATACMD_EXEC) wcnt_q <= 8'h00;
    else if (buf_take) wcnt_q <= wcnt_q + 8'h01;
  end

  // Buffer array has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (buf_take) buf_mem[wcnt_q] <= wr_data;
    buf_rd_q <= buf_mem[buf_rd_addr];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) id_q <= 16'h0000;
    else id_q <= (id_index == 8'(`ATACMD_SMART_WORD)) ? (16'h0001 << `ATACMD_SMART_BIT) : 16'h0000;
  end

  // Status: bit0 done, bit1 abort, bit2 sleep entered; set wins over clear
  wire [2:0] events = {state_q == ATACMD_EXEC && is_stby, state_q == ATACMD_EXEC && exec_abort,
                       state_q == ATACMD_DONE};
  wire clr_hit = reg_write && reg_addr == `ATACMD_ADR_CLEAR;
  wire en_hit = reg_write && reg_addr == `ATACMD_ADR_ENABLE;
  wire [2:0] clr_bits = clr_hit ? reg_wdata[2:0] : 3'b000;

  // One sticky bit per event; a same-cycle event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_status
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          status_q[gi] <= 1'b0;
        end else begin
          status_q[gi] <= events[gi] | (status_q[gi] & ~clr_bits[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_q <= 3'b000;
    end else if (en_hit) begin
      enable_q <= reg_wdata[2:0];
    end
  end

  // Read selection, one named word per register
  wire [31:0] rd_status = {29'h0, status_q};
  wire [31:0] rd_enable = {29'h0, enable_q};
  wire [31:0] rd_maxlba = {4'h0, max_q};
  wire [31:0] rd_mult = {23'h0, mult_en_q, mult_q};
  wire [31:0] rd_state = {27'h0, unused_plain & 1'b0, frozen_q, locked_q, sleep_q, busy_q};
  wire sel_status = reg_addr == `ATACMD_ADR_STATUS;
  wire sel_enable = reg_addr == `ATACMD_ADR_ENABLE;
  wire sel_maxlba = reg_addr == `ATACMD_ADR_MAXLBA;
  wire sel_mult = reg_addr == `ATACMD_ADR_MULT;
  wire sel_state = reg_addr == `ATACMD_ADR_STATE;
  // Unmapped addresses read zero
  wire [31:0] rd_mux = sel_status ? rd_status :
                       sel_enable ? rd_enable :
                       sel_maxlba ? rd_maxlba :
                       sel_mult ? rd_mult :
                       sel_state ? rd_state : 32'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata_q <= 32'h0;
    else rdata_q <= reg_read ? rd_mux : 32'h0;
  end
endmodule : atacmd_core
`default_nettype wire

/* sim/atacmd_core_assertions.sv */
// Checker for the ATA command block
`timescale 1ns/10ps
`default_nettype none
`include "atacmd_defines.svh"
module atacmd_core_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_features,
  input wire logic [7:0] cmd_count,
  input wire logic [7:0] cmd_drive_head,
  input wire logic drive_id,
  input wire logic [7:0] id_index,
  input wire logic [15:0] id_word,
  input wire logic busy_flag,
  input wire logic cmd_done,
  input wire logic cmd_abort,
  input wire logic [7:0] count_out,
  input wire logic [27:0] max_lba,
  input wire logic [7:0] mult_count,
  input wire logic mult_enable,
  input wire logic sleep_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = cmd_valid && !busy_flag && !cmd_done && cmd_drive_head[4] == drive_id;
  wire mul = tk && cmd_code == `ATACMD_OP_SET_MULT;
  chk_take_busy: assert property (tk |=> busy_flag) else $error("busy not raised");
  chk_stby_seq: assert property (tk && (cmd_code == 8'h96 || cmd_code == 8'hE2)
    |=> busy_flag ##1 sleep_mode ##1 (cmd_done && !busy_flag && sleep_mode)) else $error("standby order");
  chk_stbyi_seq: assert property (tk && (cmd_code == 8'h94 || cmd_code == 8'hE0)
    |=> busy_flag ##1 sleep_mode ##1 (cmd_done && !busy_flag && sleep_mode)) else $error("immediate order");
  chk_sleep_wake: assert property (tk && sleep_mode && cmd_code == 8'h87 |-> ##2 !sleep_mode)
    else $error("no wake");
  chk_xlat_zero: assert property (tk && cmd_code == 8'h87 |-> ##3 (cmd_done && count_out == 8'h00))
    else $error("translate count");
  chk_mult_good: assert property (mul && cmd_count == 8'h01 |-> ##2 (mult_enable && mult_count == 8'h01))
    else $error("block count lost");
  chk_mult_bad: assert property (mul && cmd_count > 8'h01 |-> ##2 (cmd_abort && !mult_enable))
    else $error("bad count kept");
  chk_mult_zero: assert property (mul && cmd_count == 8'h00 |-> ##2 (!cmd_abort && !mult_enable))
    else $error("zero count");
  chk_sub_rsvd: assert property (tk && cmd_code == 8'hF9 && (cmd_features == 8'h00 || cmd_features > 8'h04)
    |-> ##2 (cmd_abort && max_lba == $past(max_lba, 2))) else $error("reserved subcode");
  chk_smart_word: assert property (id_index == 8'h52 |=> id_word == 16'h0001) else $error("word 82");
  cover property (tk && cmd_code == `ATACMD_OP_WRBUF);
  cover property (tk && sleep_mode);
  cover property (cmd_done && cmd_abort);
endmodule : atacmd_core_chk
bind atacmd_core atacmd_core_chk u_chk (.clk, .rst, .cmd_valid, .cmd_code, .cmd_features, .cmd_count,
  .cmd_drive_head, .drive_id, .id_index, .id_word, .busy_flag, .cmd_done, .cmd_abort, .count_out, .max_lba,
  .mult_count, .mult_enable, .sleep_mode);
`default_nettype wire

/* sim/atacmd_host.sv */
// Host model driving the task file and buffer words
`timescale 1ns/10ps
`default_nettype none
`include "atacmd_defines.svh"
module atacmd_host (
  input wire logic clk,
  input wire logic cmd_done,
  input wire logic wr_ready,
  output logic cmd_valid = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [7:0] cmd_features = 8'h00,
  output logic [7:0] cmd_count = 8'h00,
  output logic [7:0] cmd_lba_low = 8'h00,
  output logic [7:0] cmd_lba_mid = 8'h00,
  output logic [7:0] cmd_lba_high = 8'h00,
  output logic [7:0] cmd_drive_head = 8'h00,
  output logic wr_valid = 1'b0,
  output logic [15:0] wr_data = 16'h0000
);
  logic on = 1'b0;
  logic [8:0] k = 9'h000;
  logic [3:0] cyc = 4'h0;
  wire [8:0] nk = k + {8'h00, wr_valid && wr_ready};
  // Word held until taken; a stall every sixteen cycles
  always @(posedge clk) begin
    k <= nk;
    cyc <= cyc + 4'h1;
    if (!(wr_valid && !wr_ready)) begin
      wr_valid <= on && nk < 9'h100 && cyc != 4'hF;
      wr_data <= {~nk[7:0], nk[7:0]};
    end
  end
  // Any command also wakes a sleeping drive
  task automatic issue(input logic [7:0] op, input logic [7:0] f, input logic [7:0] c, input logic [27:0] a);
    int n;
    cmd_valid <= 1'b1;
    cmd_code <= op;
    cmd_features <= f;
    cmd_count <= c;
    {cmd_drive_head[3:0], cmd_lba_high, cmd_lba_mid, cmd_lba_low} <= a;
    cmd_drive_head[7:4] <= 4'hE;
    on <= op == `ATACMD_OP_WRBUF;
    @(posedge clk);
    cmd_valid <= 1'b0;
    {cmd_code, cmd_features, cmd_count} <= ~{op, f, c};
    n = 0;
    while (!cmd_done && n < 2000) begin
      @(posedge clk);
      n++;
    end
    on <= 1'b0;
  endtask : issue
  task automatic set_max(input logic [7:0] f, input logic [7:0] c, input logic [27:0] a);
    issue(`ATACMD_OP_READ_NATIVE, 8'h00, 8'h00, 28'h0000000);
    issue(`ATACMD_OP_SET_MAX, f, c, a);
  endtask : set_max
endmodule : atacmd_host
`default_nettype wire

/* sim/tb.sv */
// Testbench for the ATA command block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] id_index = 8'h00, buf_rd_addr = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [7:0] ftab [3] = '{8'h00, 8'h05, 8'hFF};
  logic [7:0] stab [4] = '{8'h96, 8'hE2, 8'h94, 8'hE0};
  logic [7:0] mtab [4] = '{8'h01, 8'h02, 8'h01, 8'h00};
  logic [1:0] mexp [4] = '{2'h1, 2'h2, 2'h1, 2'h0};
  wire cmd_valid, wr_valid, wr_ready, busy_flag, device_ready_flag, cmd_done, cmd_abort, mult_enable, sleep_mode, irq;
  wire [7:0] cmd_code, cmd_features, cmd_count, cmd_lba_low, cmd_lba_mid, cmd_lba_high, cmd_drive_head;
  wire [7:0] count_out, mult_count;
  wire [15:0] wr_data, id_word, buf_rd_data;
  wire [27:0] max_lba;
  wire [31:0] reg_rdata;
  int n_mismatch = 0, checks_done = 0;
  always #2 clk = ~clk;
  atacmd_core u_atacmd_core (.clk, .rst, .cmd_valid, .cmd_code, .cmd_features, .cmd_count, .cmd_lba_low,
    .cmd_lba_mid, .cmd_lba_high, .cmd_drive_head, .drive_id(1'b0), .wr_valid, .wr_data, .wr_ready, .id_index,
    .id_word, .busy_flag, .device_ready_flag, .cmd_done, .cmd_abort, .count_out, .max_lba, .mult_count,
    .mult_enable, .sleep_mode, .set_max_locked(), .set_max_frozen(), .buf_rd_data, .buf_rd_addr, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);
  atacmd_host u_atacmd_host (.clk, .cmd_done, .wr_ready, .cmd_valid, .cmd_code, .cmd_features, .cmd_count,
    .cmd_lba_low, .cmd_lba_mid, .cmd_lba_high, .cmd_drive_head, .wr_valid, .wr_data);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    check(reg_rdata, e);
  endtask : reg_rd
  task automatic peek(input logic [7:0] a, input logic [15:0] ide, input logic [15:0] bufe);
    @(posedge clk);
    id_index <= a;
    buf_rd_addr <= a;
    repeat (2) @(posedge clk);
    check({id_word, buf_rd_data}, {ide, bufe});
  endtask : peek
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({mult_enable, max_lba}, 32'h0FFFFFF);
    u_atacmd_host.issue(8'hF9, 8'h01, 8'h00, 28'h0000100);
    check(32'(cmd_abort), 32'h1);
    foreach (ftab[i]) begin
      u_atacmd_host.set_max(ftab[i], 8'h00, 28'h0000200);
      check({cmd_abort, max_lba}, 32'h10FFFFFF);
    end
    u_atacmd_host.set_max(8'h01, 8'h01, 28'h0123456);
    check({cmd_abort, max_lba}, 32'h0123456);
    u_atacmd_host.set_max(8'h01, 8'h01, 28'h0000777);
    check({cmd_abort, max_lba}, 32'h10123456);
    u_atacmd_host.set_max(8'h01, 8'h00, 28'h0000ABC);
    check({cmd_abort, max_lba}, 32'h0000ABC);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(max_lba), 32'h0123456);
    foreach (mtab[i]) begin
      u_atacmd_host.issue(8'hC6, 8'h00, mtab[i], 28'h0);
      check(32'({cmd_abort, mult_enable}), 32'(mexp[i]));
    end
    reg_wr(4'h1, 32'h7);
    reg_rd(4'h1, 32'h7);
    foreach (stab[i]) begin
      reg_wr(4'h2, 32'h7);
      u_atacmd_host.issue(stab[i], 8'h00, 8'h00, 28'h0);
      reg_rd(4'h0, 32'h5);
      check(32'({sleep_mode, busy_flag, irq}), 32'h5);
    end
    reg_wr(4'h1, 32'h0);
    @(posedge clk);
    check(32'(irq), 32'h0);
    reg_wr(4'h1, 32'h7);
    reg_wr(4'h2, 32'h7);
    reg_rd(4'h0, 32'h0);
    reg_rd(4'hF, 32'h0);
    check(32'(irq), 32'h0);
    u_atacmd_host.issue(8'h87, 8'h00, 8'h5A, 28'h0);
    check(32'({sleep_mode, count_out}), 32'h0);
    u_atacmd_host.issue(8'hE8, 8'h00, 8'h00, 28'h0);
    check(32'(cmd_abort), 32'h0);
    peek(8'h05, 16'h0000, 16'hFA05);
    peek(8'h52, 16'h0001, 16'hAD52);
    peek(8'hFF, 16'h0000, 16'h00FF);
    close_out;
  end
endmodule : tb
`default_nettype wire
